// ==== hw/pdsi_pkg.sv ====
// Package: constants, types and register map of the PHY diagnostic/status/interrupt bank
//
// Behaviour
// - Writing one to the diagnostic start bit launches a cable test, and the bit clears itself when the test ends.
// - The start bit reads one while a test runs and zero after it, when status and result are valid.
// - Writing zero to the start bit stops a running cable test instead of launching one.
// - A two-bit read/write pair select (00 A, 01 B, 10 C, 11 D) picks the tested pair and resets to 00.
// - A read-only two-bit status gives 00 no fault, 01 open, 10 short, 11 test failed, reset 00.
// - A read-only eight-bit result holds the distance to an open or short fault and resets to zero.
// - Link status bit 1 reads one while the gigabit link is up and zero while it is down.
// - Link status bit 0 reads one while the 100 Mb/s link is up and zero while it is down.
// - A sixteen-bit counter counts received frames with symbol errors, clears on read, resets to zero.
// - Eight read/write enables in bits 15..8 gate the interrupt sources and reset to zero.
// - Flags 7, 6 and 5 catch jabber, receive error and page received, clear on read, reset to zero.
// - Flags 4 and 3 catch parallel detect fault and partner acknowledge, clear on read, reset zero.
// - Flags 2, 1 and 0 catch link down, remote fault and link up, clear on read, reset to zero.
package pdsi_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int DIAG_TIMEOUT_US = 100;
  // Longest wait rounds down to whole cycles
  localparam int DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000);

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_DIAG = 6'h12;
  localparam logic [5:0] IDX_LINK = 6'h13;
  localparam logic [5:0] IDX_SYMERR = 6'h15;
  localparam logic [5:0] IDX_INTR = 6'h1b;
  localparam logic [5:0] IDX_CORE_STAT = 6'h30;
  localparam logic [5:0] IDX_CORE_MASK = 6'h31;

  // ==========================================================
  // Field positions and reset values
  localparam int DIAG_START_BIT = 15;
  localparam int DIAG_RSV14_BIT = 14;
  localparam int DIAG_PAIR_LSB = 12;
  localparam int DIAG_RSV_LSB = 10;
  localparam int DIAG_STAT_LSB = 8;
  localparam logic [1:0] DIAG_PAIR_RST = 2'h0;
  localparam logic [1:0] DIAG_RSV_RST = 2'h0;
  localparam logic [1:0] DIAG_STAT_RST = 2'h0;
  localparam logic [1:0] DIAG_STAT_FAILED = 2'h3;
  localparam logic [7:0] DIAG_RES_RST = 8'h00;
  localparam logic [7:0] INTR_EN_RST = 8'h00;
  localparam int INTR_EN_LSB = 8;
  localparam int INTR_FLAG_W = 8;
  localparam int ADR_IDX_LSB = 2;
  localparam int ADR_IDX_W = 6;
  localparam int CORE_EV_DIAG_DONE = 0;
  localparam int CORE_EV_CNT_WRAP = 1;
  localparam int CORE_EV_W = 2;
  localparam logic [CORE_EV_W-1:0] CORE_MASK_RST = 2'h0;

  // ==========================================================
  // Types
  typedef enum logic [0:0] {
    PDSI_ST_IDLE = 1'b0,
    PDSI_ST_RUN = 1'b1
  } pdsi_diag_st_t;

  // Outcome reported by the cable measurement front end
  typedef struct packed {
    logic [1:0] status;
    logic [7:0] distance;
  } pdsi_diag_res_t;

  // Event order matches flag bits 7..0
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_rcvd;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } pdsi_evt_t;

endpackage : pdsi_pkg

// ==== hw/pdsi_sticky_flags.sv ====
// Sticky flag bank: a set pulse holds a flag until a clear, set wins over clear
`timescale 1ns/10ps
module pdsi_sticky_flags #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Set and clear per flag
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // Flag state
  output logic [W-1:0] flags_o
);

  logic [W-1:0] flags_ff;

  // ==========================================================
  // One flop per flag
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flags_ff[i] <= 1'b0;
      end else if (set_i[i]) begin
        // Event beside a clear must not be lost
        flags_ff[i] <= 1'b1;
      end else if (clr_i[i]) begin
        flags_ff[i] <= 1'b0;
      end
    end
  end

  assign flags_o = flags_ff;

endmodule : pdsi_sticky_flags

// ==== hw/pdsi_err_counter.sv ====
// Clear-on-read event counter with wrap pulse
`timescale 1ns/10ps
module pdsi_err_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Count and clear
  input wire logic inc_i,
  input wire logic clr_i,
  // State
  output logic [W-1:0] count_o,
  output logic wrap_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // ==========================================================
  // Increment in the clearing cycle survives as a count of one
  assign nxt_cnt = clr_i ? W'(inc_i) : cnt_ff + W'(inc_i);
  assign wrap_o = inc_i & ~clr_i & (&cnt_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign count_o = cnt_ff;

endmodule : pdsi_err_counter

// ==== hw/pdsi_regs.sv ====
// Per-port PHY cable diagnostic, link status, error count and interrupt register bank
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
module pdsi_regs
  import pdsi_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int CNT_W = 16,
  parameter int TIMEOUT_CYC = DIAG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Cable measurement front end
  output logic diag_start_o,
  output logic diag_abort_o,
  output logic [1:0] diag_pair_o,
  input wire logic diag_done_i,
  input wire pdsi_diag_res_t diag_res_i,
  // Link and receive status
  input wire logic link_1000_up_i,
  input wire logic link_100_up_i,
  input wire logic sym_err_frame_i,
  input wire pdsi_evt_t evt_i,
  // Interrupts
  output logic port_irq_o,
  output logic irq_o
);

  // ==========================================================
  // Bus decode
  logic ack_ff;
  logic [31:0] dat_ff;
  logic req;
  logic wr_en;
  logic rd_en;
  logic wr_lo;
  logic wr_hi;
  logic [ADR_IDX_W-1:0] idx;
  logic [15:0] wdat;
  logic hit_diag;
  logic hit_link;
  logic hit_symerr;
  logic hit_intr;
  logic hit_cstat;
  logic hit_cmask;

  // One request per handshake, ack rises the cycle after it
  assign req = cyc_i & stb_i & ~ack_ff;
  assign wr_en = req & we_i;
  assign rd_en = req & ~we_i;
  assign wr_lo = wr_en & sel_i[0];
  assign wr_hi = wr_en & sel_i[1];
  assign idx = adr_i[ADR_IDX_LSB +: ADR_IDX_W];
  // Upper half of the bus word carries no register bits
  assign wdat = dat_i[15:0];
  assign hit_diag = (idx == IDX_DIAG);
  assign hit_link = (idx == IDX_LINK);
  assign hit_symerr = (idx == IDX_SYMERR);
  assign hit_intr = (idx == IDX_INTR);
  assign hit_cstat = (idx == IDX_CORE_STAT);
  assign hit_cmask = (idx == IDX_CORE_MASK);

  // ==========================================================
  // Cable diagnostic control
  pdsi_diag_st_t diag_st_ff;
  pdsi_diag_st_t nxt_diag_st;
  logic [1:0] pair_ff;
  logic rsv14_ff;
  logic [1:0] rsv_ff;
  logic [1:0] dstat_ff;
  logic [7:0] dres_ff;
  // Counter sized from the time-out so a longer wait cannot wrap early
  localparam int TMO_W = (TIMEOUT_CYC > 1) ? $clog2(TIMEOUT_CYC) : 1;
  logic [TMO_W-1:0] tmo_ff;
  logic [TMO_W-1:0] nxt_tmo;
  logic start_ff;
  logic abort_ff;
  logic diag_wr;
  logic diag_go;
  logic diag_stop;
  logic diag_tmo;
  logic diag_fin;
  logic diag_run;
  logic wr_start;
  logic wr_rsv14;
  logic [1:0] wr_pair;
  logic [1:0] wr_rsv;
  logic pair_load;
  logic [1:0] nxt_dstat;
  logic [7:0] nxt_dres;

  assign diag_run = (diag_st_ff == PDSI_ST_RUN);
  assign wr_start = wdat[DIAG_START_BIT];
  assign wr_rsv14 = wdat[DIAG_RSV14_BIT];
  assign wr_pair = wdat[DIAG_PAIR_LSB +: 2];
  assign wr_rsv = wdat[DIAG_RSV_LSB +: 2];
  assign diag_wr = wr_hi & hit_diag;
  assign diag_go = diag_wr & wr_start & ~diag_run;
  assign diag_stop = diag_wr & ~wr_start & diag_run;
  assign diag_tmo = diag_run & (tmo_ff == TMO_W'(TIMEOUT_CYC - 1));
  assign diag_fin = diag_run & ~diag_stop & (diag_done_i | diag_tmo);
  assign pair_load = diag_wr & ~diag_run;
  assign nxt_tmo = diag_run ? tmo_ff + TMO_W'(1) : '0;
  // A silent front end is reported as a failed test
  assign nxt_dstat = diag_done_i ? diag_res_i.status : DIAG_STAT_FAILED;
  assign nxt_dres = diag_done_i ? diag_res_i.distance : DIAG_RES_RST;

  always_comb begin
    nxt_diag_st = diag_st_ff;
    case (diag_st_ff)
      PDSI_ST_IDLE: begin
        if (diag_go) begin
          nxt_diag_st = PDSI_ST_RUN;
        end
      end
      PDSI_ST_RUN: begin
        // Self clear on completion, or on a written zero
        if (diag_stop || diag_fin) begin
          nxt_diag_st = PDSI_ST_IDLE;
        end
      end
      default: begin
        nxt_diag_st = PDSI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      diag_st_ff <= PDSI_ST_IDLE;
    end else begin
      diag_st_ff <= nxt_diag_st;
    end
  end

  // Pulses to the front end, one cycle after the write is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      start_ff <= diag_go;
      abort_ff <= diag_stop;
    end
  end

  // Time-out counter runs only while a test is in progress
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_ff <= '0;
    end else begin
      tmo_ff <= nxt_tmo;
    end
  end

  // Pair is frozen while a test runs so the front end sees one pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_ff <= DIAG_PAIR_RST;
    end else if (pair_load) begin
      pair_ff <= wr_pair;
    end
  end

  // Reserved bits read back what was last written while no test was running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsv14_ff <= 1'b0;
      rsv_ff <= DIAG_RSV_RST;
    end else if (pair_load) begin
      rsv14_ff <= wr_rsv14;
      rsv_ff <= wr_rsv;
    end
  end

  // Status and result stay put until a test completes or times out, an abort leaves them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dstat_ff <= DIAG_STAT_RST;
      dres_ff <= DIAG_RES_RST;
    end else if (diag_fin) begin
      dstat_ff <= nxt_dstat;
      dres_ff <= nxt_dres;
    end
  end

  assign diag_start_o = start_ff;
  assign diag_abort_o = abort_ff;
  assign diag_pair_o = pair_ff;

  // ==========================================================
  // Symbol error frame counter
  logic [CNT_W-1:0] symerr_cnt;
  logic symerr_wrap;
  logic symerr_rd;
  logic symerr_inc;

  assign symerr_rd = rd_en & hit_symerr;
  // Frame pulse is taken as already synchronous to the core clock
  assign symerr_inc = sym_err_frame_i;

  pdsi_err_counter #(
    .W(CNT_W)
  ) u_symerr_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(symerr_inc),
    .clr_i(symerr_rd),
    .count_o(symerr_cnt),
    .wrap_o(symerr_wrap)
  );

  // ==========================================================
  // Port interrupt enables and clear-on-read flags
  logic [INTR_FLAG_W-1:0] intr_en_ff;
  logic [INTR_FLAG_W-1:0] intr_flags;
  logic [INTR_FLAG_W-1:0] intr_clr;
  logic [INTR_FLAG_W-1:0] intr_pend;
  logic [INTR_FLAG_W-1:0] wr_intr_en;
  logic intr_rd;
  logic intr_en_load;

  assign intr_rd = rd_en & hit_intr;
  // A read clears every flag at once, an event in that cycle still lands
  assign intr_clr = {INTR_FLAG_W{intr_rd}};
  assign intr_en_load = wr_hi & hit_intr;
  assign wr_intr_en = wdat[INTR_EN_LSB +: INTR_FLAG_W];
  assign intr_pend = intr_flags & intr_en_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intr_en_ff <= INTR_EN_RST;
    end else if (intr_en_load) begin
      intr_en_ff <= wr_intr_en;
    end
  end

  pdsi_sticky_flags #(
    .W(INTR_FLAG_W)
  ) u_intr_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(evt_i),
    .clr_i(intr_clr),
    .flags_o(intr_flags)
  );

  assign port_irq_o = |intr_pend;

  // ==========================================================
  // Block event status, write one to clear, and mask
  logic [CORE_EV_W-1:0] core_mask_ff;
  logic [CORE_EV_W-1:0] core_stat;
  logic [CORE_EV_W-1:0] core_set;
  logic [CORE_EV_W-1:0] core_clr;
  logic [CORE_EV_W-1:0] core_pend;
  logic core_clr_wr;
  logic core_mask_load;

  // Events raised by the cable test and the counter
  assign core_set[CORE_EV_DIAG_DONE] = diag_fin;
  assign core_set[CORE_EV_CNT_WRAP] = symerr_wrap;
  assign core_clr_wr = wr_lo & hit_cstat;
  assign core_mask_load = wr_lo & hit_cmask;
  // Write one to clear, a new event in the same cycle wins
  assign core_clr = core_clr_wr ? wdat[CORE_EV_W-1:0] : '0;
  assign core_pend = core_stat & core_mask_ff;

  pdsi_sticky_flags #(
    .W(CORE_EV_W)
  ) u_core_stat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(core_set),
    .clr_i(core_clr),
    .flags_o(core_stat)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_mask_ff <= CORE_MASK_RST;
    end else if (core_mask_load) begin
      core_mask_ff <= wdat[CORE_EV_W-1:0];
    end
  end

  assign irq_o = |core_pend;

  // ==========================================================
  // Read data selection
  logic [15:0] rd_diag;
  logic [15:0] rd_link;
  logic [1:0] link_now;
  logic [15:0] rd_symerr;
  logic [15:0] rd_intr;
  logic [15:0] rd_cstat;
  logic [15:0] rd_cmask;
  logic [15:0] rd_word;

  assign rd_diag = {diag_st_ff == PDSI_ST_RUN, rsv14_ff, pair_ff, rsv_ff, dstat_ff, dres_ff};
  assign link_now = {link_1000_up_i, link_100_up_i};
  assign rd_link = {14'h0000, link_now};
  assign rd_symerr = 16'(symerr_cnt);
  assign rd_intr = {intr_en_ff, intr_flags};
  assign rd_cstat = 16'(core_stat);
  assign rd_cmask = 16'(core_mask_ff);
  // Unmapped indices answer with zero
  assign rd_word = hit_diag ? rd_diag :
                   hit_link ? rd_link :
                   hit_symerr ? rd_symerr :
                   hit_intr ? rd_intr :
                   hit_cstat ? rd_cstat :
                   hit_cmask ? rd_cmask : 16'h0000;

  logic [31:0] nxt_dat;

  assign nxt_dat = {16'h0000, rd_word};

  // Ack is a one-cycle pulse, the decode above refuses a second take
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // Value before any clear-on-read side effect is returned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      dat_ff <= nxt_dat;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

endmodule : pdsi_regs

// ==== testbench/pdsi_regs_properties.sv ====
// Bus and register checks for the PHY diagnostic register bank
`timescale 1ns/10ps
module pdsi_regs_properties
  import pdsi_pkg::*;
#(
  parameter int ADR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Front end and status
  input wire logic diag_start_o,
  input wire logic diag_abort_o,
  input wire logic [1:0] diag_pair_o,
  input wire logic link_1000_up_i,
  input wire logic link_100_up_i,
  input wire pdsi_evt_t evt_i,
  input wire logic port_irq_o
);
  // ==========================================================
  // Request decode
  wire tk = cyc_i & stb_i & ~ack_o;
  wire [5:0] ix = adr_i[7:2];
  wire dwr = tk & we_i & (ix == IDX_DIAG) & sel_i[1];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(logic [5:0] i);
    tk && !we_i && ix == i;
  endsequence
  // ==========================================================
  // Properties
  a_ack_next:
    assert property (tk |=> ack_o) else $error("no ack after request");
  a_ack_single:
    assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_read_upper:
    assert property (ack_o |-> dat_o[31:16] == 16'h0) else $error("upper data not zero");
  a_start_cause:
    assert property (diag_start_o |-> $past(dwr && dat_i[15])) else $error("bad start");
  a_abort_cause:
    assert property (diag_abort_o |-> $past(dwr && !dat_i[15])) else $error("bad abort");
  a_pair_write:
    assert property ($changed(diag_pair_o) && !$past(rst_i) |-> $past(dwr))
      else $error("pair changed without write");
  a_link_live:
    assert property (s_rd(IDX_LINK) |=>
      dat_o[15:0] == {14'h0, $past(link_1000_up_i), $past(link_100_up_i)})
      else $error("link status wrong");
  a_irq_drop:
    assert property (s_rd(IDX_INTR) ##0 (evt_i == 8'h0) |=> !port_irq_o)
      else $error("irq stays after flag read");
endmodule : pdsi_regs_properties

bind pdsi_regs pdsi_regs_properties #(.ADR_W(ADR_W)) u_pdsi_regs_properties (.clk_i, .rst_i,
  .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .diag_start_o,
  .diag_abort_o, .diag_pair_o, .link_1000_up_i, .link_100_up_i, .evt_i, .port_irq_o);

// ==== testbench/tb.sv ====
// Self-checking bench for the PHY diagnostic register bank
`timescale 1ns/10ps
module tb;
  import pdsi_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, diag_start_o, diag_abort_o, port_irq_o, irq_o;
  logic [1:0] diag_pair_o;
  logic diag_done_i = 0, link_1000_up_i = 0, link_100_up_i = 0, sym_err_frame_i = 0;
  pdsi_diag_res_t diag_res_i = '0;
  pdsi_evt_t evt_i = '0;
  int fail_count = 0, checks_done = 0;
  logic [15:0] q, m;
  // Short time-out keeps the failed-test case quick
  pdsi_regs #(.TIMEOUT_CYC(20)) u_pdsi_regs (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .diag_start_o, .diag_abort_o, .diag_pair_o,
    .diag_done_i, .diag_res_i, .link_1000_up_i, .link_100_up_i, .sym_err_frame_i,
    .evt_i, .port_irq_o, .irq_o);
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chkb(input logic g, e);
    chk({15'h0, g}, {15'h0, e});
  endtask : chkb
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0);
    chk(q, e);
  endtask : rd
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // ==========================================================
  // Tests
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h48, 16'h0);
    rd(8'h54, 16'h0);
    rd(8'h6c, 16'h0);
    rd(8'h80, 16'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) {link_1000_up_i, link_100_up_i} <= i[1:0];
      rd(8'h4c, 16'(i));
    end
    $display("link test done");
    wb(1'b1, 8'h6c, 16'hffff);
    rd(8'h6c, 16'hff00);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i) evt_i <= pdsi_evt_t'(8'h1 << i);
      @(posedge clk_i) evt_i <= '0;
      @(posedge clk_i);
      chkb(port_irq_o, 1'b1);
      rd(8'h6c, 16'hff00 | (16'h1 << i));
      chkb(port_irq_o, 1'b0);
      rd(8'h6c, 16'hff00);
    end
    // Masked events still latch but stay quiet
    wb(1'b1, 8'h6c, 16'h0);
    @(posedge clk_i) evt_i <= pdsi_evt_t'(8'hff);
    @(posedge clk_i) evt_i <= '0;
    @(posedge clk_i);
    chkb(port_irq_o, 1'b0);
    rd(8'h6c, 16'h00ff);
    $display("interrupt test done");
    repeat (3) begin
      @(posedge clk_i) sym_err_frame_i <= 1'b1;
      @(posedge clk_i) sym_err_frame_i <= 1'b0;
    end
    rd(8'h54, 16'h3);
    rd(8'h54, 16'h0);
    $display("counter test done");
    wb(1'b1, 8'hc4, 16'h1);
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, 8'h48, {2'b10, p[1:0], 12'h0});
      chkb(diag_start_o, 1'b1);
      // Result of the previous test still stands while this one runs
      m = (p == 0) ? 16'h0000 : {6'h00, 2'(p - 1), 8'h5a};
      rd(8'h48, {2'b10, p[1:0], 12'h0} | m);
      chk({14'h0, diag_pair_o}, 16'(p));
      @(posedge clk_i) diag_res_i <= {p[1:0], 8'h5a};
      diag_done_i <= 1'b1;
      @(posedge clk_i) diag_done_i <= 1'b0;
      // Distance is only meaningful for open and short
      m = (p == 1 || p == 2) ? 16'hffff : 16'hff00;
      wb(1'b0, 8'h48, 16'h0);
      chk(q & m, {2'b00, p[1:0], 2'b00, p[1:0], 8'h5a} & m);
      chkb(irq_o, 1'b1);
      wb(1'b1, 8'hc0, 16'h1);
      chkb(irq_o, 1'b0);
    end
    wb(1'b1, 8'h48, 16'ha000);
    repeat (30) @(posedge clk_i);
    wb(1'b0, 8'h48, 16'h0);
    chk(q & 16'hff00, 16'h2300);
    wb(1'b1, 8'hc0, 16'h3);
    wb(1'b1, 8'h48, 16'ha000);
    wb(1'b1, 8'h48, 16'h2000);
    chkb(diag_abort_o, 1'b1);
    wb(1'b0, 8'h48, 16'h0);
    chk(q & 16'hff00, 16'h2300);
    rd(8'hc0, 16'h0);
    $display("diagnostic test done");
    // Full wrap of the counter raises the masked core wrap flag
    @(posedge clk_i) sym_err_frame_i <= 1'b1;
    repeat (65536) @(posedge clk_i);
    sym_err_frame_i <= 1'b0;
    rd(8'h54, 16'h0);
    rd(8'hc0, 16'h2);
    chkb(irq_o, 1'b0);
    $display("wrap test done");
    end_sim;
  end
  // Counter wrap takes about 66000 cycles, the rest well under a thousand
  initial begin
    repeat (80000) @(posedge clk_i);
    fail_count++;
    end_sim;
  end
endmodule : tb
